// File: bench/host_model.sv
// host side model: serves pending events and restarts the watchdog
`timescale 1ns/1ns
module host_model (
	// clock and bench control
	input wire          clk_i,
	input wire          rstn_i,
	input wire          serve_i,
	input wire          kick_i,
	// device side
	input wire          irq_i,
	input wire  [351:0] pending_i,
	output reg  [351:0] clear_o,
	output reg          restart_o
);
	initial clear_o = 352'h0;
	initial restart_o = 1'b0;
	always @(posedge clk_i) begin
		// clears only what it saw, so a newer event survives
		clear_o <= (serve_i && irq_i && rstn_i) ? pending_i : 352'h0;
		restart_o <= kick_i && rstn_i;
	end
endmodule // host_model

// File: bench/motion_host_interrupt_unit_sva.sv
// concurrent checks on the motion host interrupt unit ports
`timescale 1ns/1ns
`include "motion_host_interrupt_unit_defines.vh"
module motion_host_interrupt_unit_sva #(
	parameter AXIS_COUNT = 8
) (
	// clock, reset and host control
	input wire         clk_i,
	input wire         rstn_i,
	input wire         emergency_stop_event_i,
	input wire         global_int_enable_i,
	input wire [351:0] event_enable_i,
	input wire [351:0] event_clear_i,
	input wire [2:0]   wdt_action_i,
	// watched outputs
	input wire [351:0] event_pending_o,
	input wire         host_irq_o,
	input wire         wdt_timeout_o,
	input wire         wdt_servo_off_o,
	input wire         wdt_dout_off_o,
	input wire         wdt_pwm_off_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	axis_resv_a: assert property ((event_pending_o[31:0] & ~`AXIS_VALID_MASK) == 0)
		else $error("axis reserved bit set");
	sys_resv_a: assert property ((event_pending_o[287:256] & ~`SYS_VALID_MASK) == 0)
		else $error("system reserved bit set");
	di_unused_a: assert property (
		event_pending_o[319:312] == 0 && event_pending_o[351:344] == 0)
		else $error("unused input edge bit set");
	silent_axes_a: assert property (AXIS_COUNT <= 4 |-> event_pending_o[255:128] == 0)
		else $error("absent axis item raised");
	emg_map_a: assert property (
		emergency_stop_event_i |=> event_pending_o[256] && event_pending_o[6])
		else $error("emergency not mapped");
	pending_hold_a: assert property (
		$past(rstn_i) |->
		($past(event_pending_o) & ~$past(event_clear_i) & ~event_pending_o) == 0)
		else $error("pending bit lost without clear");
	clear_drop_a: assert property (
		event_clear_i[256] && !emergency_stop_event_i |=> !event_pending_o[256])
		else $error("clear ignored");
	irq_or_a: assert property (
		$past(rstn_i) |->
		host_irq_o == $past(global_int_enable_i && |(event_pending_o & event_enable_i)))
		else $error("irq not the gated or of pending");
	no_global_a: assert property (!global_int_enable_i |=> !host_irq_o)
		else $error("irq without global enable");
	wdt_action_a: assert property (
		$rose(wdt_timeout_o) |->
		{wdt_pwm_off_o, wdt_dout_off_o, wdt_servo_off_o} == $past(wdt_action_i))
		else $error("timeout actions wrong");
endmodule // motion_host_interrupt_unit_sva

// File: bench/tb.sv
// self-checking bench for the motion host interrupt unit
`timescale 1ns/1ns
`include "motion_host_interrupt_unit_defines.vh"
`define chk(nm, e, s) n_tests++; if ((s) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end
module tb;
	reg clk_i, rstn_i = 0, mc = 0, gie = 1, serve = 0, kick = 0;
	reg  [166:0] src = 0;
	reg  [23:0]  pins = 0;
	reg  [351:0] ena = ~352'h0;
	reg  [31:0]  period = 32'h0000_0000;
	reg  [2:0]   action = 3'h0;
	wire [351:0] pend, clr;
	wire         irq, tmo, s_off, d_off, p_off, restart;
	integer      n_errors = 0, n_tests = 0, i;
	int src_r[23] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13, 15, 16, 18, 19,
		79, 161, 162, 163, 164, 165, 166};
	int exp_r[23] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13, 15, 16, 18, 19,
		115, 257, 258, 259, 260, 261, 262};
	motion_host_interrupt_unit #(.AXIS_COUNT(4)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.motion_cycle_i(mc), .axis_events_i(src[159:0]), .emergency_stop_event_i(src[160]),
		.linear_cmp0_done_event_i(src[161]), .linear_cmp1_done_event_i(src[162]),
		.queue_cmp0_done_event_i(src[163]), .queue_cmp1_done_event_i(src[164]),
		.motion_loop_overload_event_i(src[165]), .job_loop_overload_event_i(src[166]),
		.isolated_input_i(pins[7:0]), .logic_level_input_i(pins[23:8]), .global_int_enable_i(gie),
		.event_enable_i(ena), .event_clear_i(clr), .wdt_period_i(period), .wdt_action_i(action),
		.wdt_restart_i(restart), .event_pending_o(pend), .host_irq_o(irq), .wdt_timeout_o(tmo),
		.wdt_servo_off_o(s_off), .wdt_dout_off_o(d_off), .wdt_pwm_off_o(p_off));
	host_model i_host (.clk_i(clk_i), .rstn_i(rstn_i), .serve_i(serve), .kick_i(kick),
		.irq_i(irq), .pending_i(pend), .clear_o(clr), .restart_o(restart));
	task tick; @(negedge clk_i) mc = 1; @(negedge clk_i) mc = 0; repeat (4) @(negedge clk_i); endtask
	task kick_wd; @(negedge clk_i) kick = 1; @(negedge clk_i) kick = 0; repeat (2) @(negedge clk_i); endtask
	task pulse(input integer s); @(negedge clk_i) src[s] = 1; @(negedge clk_i) src = 0; repeat (3) @(negedge clk_i); endtask
	task drain; serve = 1; repeat (4) @(negedge clk_i); serve = 0; endtask
	task results;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk_i = 0;
		forever #20 clk_i = ~clk_i;
	end
	// whole run is a few hundred cycles; this is far beyond it
	initial begin
		#1_000_000;
		n_errors++;
		results;
	end
	initial begin
		repeat (12) @(negedge clk_i);
		rstn_i = 1;
		tick; // first tick after reset only takes a sample
		for (i = 0; i < 23; i++) begin
			pulse(src_r[i]);
			`chk("pending", 352'h1 << exp_r[i], pend)
			`chk("irq", 1'b1, irq)
			drain;
			`chk("cleared", 352'h0, pend)
		end
		gie = 0;
		pulse(160);
		`chk("emergency", {64'h0, 32'h0000_0001, 128'h0, {4{32'h0000_0040}}}, pend)
		`chk("irq gated", 1'b0, irq)
		ena = 352'h0; gie = 1; repeat (3) @(negedge clk_i);
		`chk("irq masked", 1'b0, irq)
		ena = 352'h1 << 256; repeat (3) @(negedge clk_i);
		`chk("irq unmasked", 1'b1, irq)
		ena = ~352'h0; drain;
		pins = 24'h80_0001; repeat (6) @(negedge clk_i);
		`chk("no tick", 352'h0, pend)
		tick;
		`chk("rise", {32'h0, 32'h0080_0001, 288'h0}, pend)
		pins = 24'h00_0000; repeat (6) @(negedge clk_i); tick;
		`chk("fall", {32'h0080_0001, 32'h0080_0001, 288'h0}, pend)
		drain;
		action = 3'h5; period = 32'h0000_0003; kick_wd; tick; tick;
		`chk("early", 1'b0, tmo)
		kick_wd; tick; tick;
		`chk("restarted", 1'b0, tmo)
		tick;
		`chk("timeout", 1'b1, tmo)
		`chk("actions", 3'h5, {p_off, d_off, s_off})
		rstn_i = 0; repeat (2) @(negedge clk_i); rstn_i = 1; @(negedge clk_i);
		`chk("reset timeout", 1'b0, tmo)
		results;
	end
endmodule // tb
bind motion_host_interrupt_unit motion_host_interrupt_unit_sva #(.AXIS_COUNT(AXIS_COUNT)) i_sva (
	.clk_i, .rstn_i, .emergency_stop_event_i, .global_int_enable_i, .event_enable_i,
	.event_clear_i, .wdt_action_i, .event_pending_o, .host_irq_o, .wdt_timeout_o,
	.wdt_servo_off_o, .wdt_dout_off_o, .wdt_pwm_off_o);

// File: inc/motion_host_interrupt_unit_defines.vh
// constants for the motion host interrupt unit
`ifndef MOTION_HOST_INTERRUPT_UNIT_DEFINES_VH
`define MOTION_HOST_INTERRUPT_UNIT_DEFINES_VH

`define ITEM_COUNT          11
`define ITEM_AXIS_LAST      7
`define ITEM_SYSTEM         8
`define ITEM_RISE           9
`define ITEM_FALL           10
`define ITEM_WIDTH          32
`define AXIS_EVENT_COUNT    20
`define AXIS_VALID_MASK     32'h000D_BF7F
`define SYS_VALID_MASK      32'h0000_007F
`define DI_VALID_MASK       32'h00FF_FFFF
`define BIT_ALARM           0
`define BIT_POS_LIMIT       1
`define BIT_NEG_LIMIT       2
`define BIT_ORIGIN          3
`define BIT_INDEX           4
`define BIT_IN_POSITION     5
`define BIT_EMERGENCY       6
`define BIT_STOP_CMD        8
`define BIT_MAX_VELOCITY    9
`define BIT_ACCEL_START     10
`define BIT_DECEL_START     11
`define BIT_MOTION_DONE     12
`define BIT_ABNORMAL_STOP   13
`define BIT_SOFT_POS_LIMIT  15
`define BIT_SOFT_NEG_LIMIT  16
`define BIT_PRE_DISTANCE    18
`define BIT_POST_DISTANCE   19
`define SYS_BIT_EMERGENCY   0
`define SYS_BIT_LIN_CMP0    1
`define SYS_BIT_LIN_CMP1    2
`define SYS_BIT_QUEUE_CMP0  3
`define SYS_BIT_QUEUE_CMP1  4
`define SYS_BIT_MOTION_OVL  5
`define SYS_BIT_JOB_OVL     6
`define DI_ISOLATED_COUNT   8
`define DI_LOGIC_COUNT      16
`define DI_COUNT            24
`define WDT_PERIOD_WIDTH    32
`define WDT_ACTION_WIDTH    3
`define RESET_PENDING       32'h0000_0000
`define RESET_ENABLE        32'h0000_0000

`endif

// File: src/motion_host_interrupt_unit.v
// host interrupt event gathering and watchdog timeout for a pulse motion controller
// Function
// (RQ1) host restarts watchdog before timeout; each restart reloads the full period
// (RQ2) on watchdog expiry, fire the preselected timeout actions
// (RQ3) an enabled pending event raises the hardware interrupt to the host
// (RQ4) items 0-7 axes, 8 system, 9 input rising edges, 10 input falling edges
// (RQ5) four-axis build keeps axis items 4-7 silent
// (RQ6) each item is a 32-bit field, one bit per event source
// (RQ7) axis bits 0-5: alarm, pos limit, neg limit, origin, index, in-position
// (RQ8) axis bit 6 is emergency stop, same as system bit 0
// (RQ9) axis bits 8-13, 15, 16, 18, 19 carry motion and soft-limit events
// (RQ10) reserved bits always read zero
// (RQ11) system bits 0-2: emergency, linear comparator 0 and 1 done
// (RQ12) system bits 3-4: queue comparator 0 and 1 done
// (RQ13) system bits 5-6: motion loop and job loop overload
// (RQ14) input items: bits 0-7 isolated, 8-23 logic-level inputs 0-15, rest zero
// (RQ15) falling item mirrors rising layout for high-to-low transitions
// (RQ16) inputs sampled for edges once per motion cycle
// (RQ17) no interrupt unless global enable is on
// (RQ18) interrupt is OR of enabled pending bits, gated by global enable
// (RQ19) pending bits stay set until the host clears them
`timescale 1ns/1ns
`include "motion_host_interrupt_unit_defines.vh"

module motion_host_interrupt_unit #(
	parameter AXIS_COUNT = 8
) (
	// clock and reset
	input  wire                                     clk_i,
	input  wire                                     rstn_i,
	input  wire                                     motion_cycle_i,
	// per-axis event pulses, axis n in bits [n*20 +: 20]
	input  wire [8*`AXIS_EVENT_COUNT-1:0]           axis_events_i,
	// system event pulses
	input  wire                                     emergency_stop_event_i,
	input  wire                                     linear_cmp0_done_event_i,
	input  wire                                     linear_cmp1_done_event_i,
	input  wire                                     queue_cmp0_done_event_i,
	input  wire                                     queue_cmp1_done_event_i,
	input  wire                                     motion_loop_overload_event_i,
	input  wire                                     job_loop_overload_event_i,
	// digital inputs from pins
	input  wire [`DI_ISOLATED_COUNT-1:0]            isolated_input_i,
	input  wire [`DI_LOGIC_COUNT-1:0]               logic_level_input_i,
	// host control
	input  wire                                     global_int_enable_i,
	input  wire [`ITEM_COUNT*`ITEM_WIDTH-1:0]       event_enable_i,
	input  wire [`ITEM_COUNT*`ITEM_WIDTH-1:0]       event_clear_i,
	// watchdog
	input  wire [`WDT_PERIOD_WIDTH-1:0]             wdt_period_i,
	input  wire [`WDT_ACTION_WIDTH-1:0]             wdt_action_i,
	input  wire                                     wdt_restart_i,
	// outputs
	output wire [`ITEM_COUNT*`ITEM_WIDTH-1:0]       event_pending_o,
	output reg                                      host_irq_o,
	output reg                                      wdt_timeout_o,
	output reg                                      wdt_servo_off_o,
	output reg                                      wdt_dout_off_o,
	output reg                                      wdt_pwm_off_o
);

	localparam AW = `AXIS_EVENT_COUNT;

	// three-stage pin synchronisers
	reg  [`DI_COUNT-1:0] pin_s1_q;
	reg  [`DI_COUNT-1:0] pin_s2_q;
	reg  [`DI_COUNT-1:0] pin_s3_q;
	reg  [`DI_COUNT-1:0] stable_q;
	reg  [`DI_COUNT-1:0] sample_q;
	reg                  sample_valid_q;
	wire [`DI_COUNT-1:0] agreed;
	wire [`DI_COUNT-1:0] stable_d;

	// a level is taken only once stages two and three agree
	assign agreed   = ~(pin_s2_q ^ pin_s3_q);
	assign stable_d = (agreed & pin_s2_q) | (~agreed & stable_q);

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			pin_s1_q <= {`DI_COUNT{1'b0}};
			pin_s2_q <= {`DI_COUNT{1'b0}};
			pin_s3_q <= {`DI_COUNT{1'b0}};
			stable_q <= {`DI_COUNT{1'b0}};
		end else begin
			pin_s1_q <= {logic_level_input_i, isolated_input_i}; // see (RQ14)
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			stable_q <= stable_d;
		end
	end

	// edge detection only on motion-cycle ticks; short glitches may be missed
	wire                   di_tick;
	wire [`DI_COUNT-1:0]   rise_ev;
	wire [`DI_COUNT-1:0]   fall_ev;
	wire [`ITEM_WIDTH-1:0] rise_word;
	wire [`ITEM_WIDTH-1:0] fall_word;

	assign di_tick = motion_cycle_i & sample_valid_q;
	assign rise_ev = di_tick ? (stable_q & ~sample_q) : {`DI_COUNT{1'b0}}; // see (RQ16)
	assign fall_ev = di_tick ? (~stable_q & sample_q) : {`DI_COUNT{1'b0}}; // see (RQ15)

	// bits 24 to 31 of both input items are unused and stay zero
	assign rise_word = {{(`ITEM_WIDTH-`DI_COUNT){1'b0}}, rise_ev}; // see (RQ14)
	assign fall_word = {{(`ITEM_WIDTH-`DI_COUNT){1'b0}}, fall_ev}; // see (RQ15)

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			sample_q       <= {`DI_COUNT{1'b0}};
			sample_valid_q <= 1'b0;
		end else if (motion_cycle_i) begin
			sample_q       <= stable_q; // see (RQ16)
			sample_valid_q <= 1'b1;
		end
	end

	// system item assembled on its own; bit 7 and up stay zero
	reg [`ITEM_WIDTH-1:0] sys_word;

	always @* begin
		sys_word = 32'h0000_0000;
		sys_word[`SYS_BIT_EMERGENCY]  = emergency_stop_event_i; // see (RQ11)
		sys_word[`SYS_BIT_LIN_CMP0]   = linear_cmp0_done_event_i;
		sys_word[`SYS_BIT_LIN_CMP1]   = linear_cmp1_done_event_i;
		sys_word[`SYS_BIT_QUEUE_CMP0] = queue_cmp0_done_event_i; // see (RQ12)
		sys_word[`SYS_BIT_QUEUE_CMP1] = queue_cmp1_done_event_i;
		sys_word[`SYS_BIT_MOTION_OVL] = motion_loop_overload_event_i; // see (RQ13)
		sys_word[`SYS_BIT_JOB_OVL]    = job_loop_overload_event_i;
		sys_word = sys_word & `SYS_VALID_MASK; // see (RQ10)
	end

	// raw event vector, one 32-bit word per item
	reg [`ITEM_COUNT*`ITEM_WIDTH-1:0] raw_ev;
	reg [`ITEM_WIDTH-1:0]             axis_word;
	integer                           ax;

	always @* begin
		raw_ev = {`ITEM_COUNT*`ITEM_WIDTH{1'b0}};
		axis_word = 32'h0000_0000;
		for (ax = 0; ax <= `ITEM_AXIS_LAST; ax = ax + 1) begin
			axis_word = {{(`ITEM_WIDTH-AW){1'b0}}, axis_events_i[ax*AW +: AW]}; // see (RQ7) (RQ9)
			axis_word[`BIT_EMERGENCY] = emergency_stop_event_i; // see (RQ8)
			axis_word = axis_word & `AXIS_VALID_MASK; // see (RQ10)
			// axis slots past AXIS_COUNT stay zero for the smaller build
			if (ax < AXIS_COUNT) begin
				raw_ev[ax*`ITEM_WIDTH +: `ITEM_WIDTH] = axis_word; // see (RQ4) (RQ5)
			end
		end
		raw_ev[`ITEM_SYSTEM*`ITEM_WIDTH +: `ITEM_WIDTH] = sys_word; // see (RQ4)
		raw_ev[`ITEM_RISE*`ITEM_WIDTH +: `ITEM_WIDTH]   = rise_word; // see (RQ14)
		raw_ev[`ITEM_FALL*`ITEM_WIDTH +: `ITEM_WIDTH]   = fall_word; // see (RQ15)
	end

	// sticky pending bits; a new event beats a clear in the same cycle
	// a clear held high keeps its bits low, except against a new event
	reg  [`ITEM_COUNT*`ITEM_WIDTH-1:0] pending_q;
	wire [`ITEM_COUNT*`ITEM_WIDTH-1:0] pending_d;
	wire [`ITEM_COUNT*`ITEM_WIDTH-1:0] armed;
	wire                               host_irq_d;

	assign pending_d = (pending_q & ~event_clear_i) | raw_ev; // see (RQ19) (RQ6)
	assign armed     = pending_q & event_enable_i; // see (RQ18)

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			pending_q <= {`ITEM_COUNT{`RESET_PENDING}};
		end else begin
			pending_q <= pending_d;
		end
	end
	assign event_pending_o = pending_q;

	// registered so the host line never glitches while bits are cleared
	assign host_irq_d = global_int_enable_i & (|armed); // see (RQ3) (RQ17)

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			host_irq_o <= 1'b0;
		end else begin
			host_irq_o <= host_irq_d;
		end
	end

	// watchdog: period zero disables; restart reloads the full period
	reg [`WDT_PERIOD_WIDTH-1:0] wdt_count_q;
	reg                         wdt_run_q;
	wire                        wdt_enabled;
	wire                        wdt_reload;

	// restart after a timeout reloads the count but keeps the actions latched;
	// only reset releases them; period zero clears the timeout but not the actions
	assign wdt_enabled = |wdt_period_i;
	assign wdt_reload  = wdt_restart_i | ~wdt_run_q;

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			wdt_count_q     <= 32'h0000_0000;
			wdt_run_q       <= 1'b0;
			wdt_timeout_o   <= 1'b0;
			wdt_servo_off_o <= 1'b0;
			wdt_dout_off_o  <= 1'b0;
			wdt_pwm_off_o   <= 1'b0;
		end else if (!wdt_enabled) begin
			wdt_run_q     <= 1'b0;
			wdt_timeout_o <= 1'b0;
			wdt_count_q   <= 32'h0000_0000;
		end else if (wdt_reload) begin
			wdt_count_q <= wdt_period_i; // see (RQ1)
			wdt_run_q   <= 1'b1;
		end else if (motion_cycle_i && !wdt_timeout_o) begin
			if (wdt_count_q == 32'h0000_0001) begin
				wdt_timeout_o   <= 1'b1; // see (RQ2)
				wdt_servo_off_o <= wdt_action_i[0];
				wdt_dout_off_o  <= wdt_action_i[1];
				wdt_pwm_off_o   <= wdt_action_i[2];
				wdt_count_q     <= 32'h0000_0000;
			end else begin
				wdt_count_q <= wdt_count_q - 32'h0000_0001;
			end
		end
	end

endmodule // motion_host_interrupt_unit
